// >>> hw/pic_host_port.sv
/*
 eight-input programmable interrupt controller: cpu bus port, mask,
 request and in-service registers, request output, acknowledge
 sequence and cascade select lines.
 assumes all pins are asynchronous to ref_clk and that strobes stay
 low for several clock periods.
*/
// Notes on behaviour
// R1: data port driven only when selected or acknowledging
// R2: strobes count only with chip select low
// R3: acknowledge works regardless of chip select
// R4: mask bit one blocks that request input
// R5: request register mirrors inputs in level mode, holds rising edges until accepted
// R6: in-service bit marks level being serviced
// R7: init and command words stored, never readable
// R8: address 0 read: request/in-service, or poll
// R9: address 1 read always returns mask
// R10: address 0 write: bit4 init, bit3 selects
// R11: address 1 writes: init words, then mask
// R12: cpu never drives both strobes together
// R13: inputs edge or level triggered per init
// R14: after init, unmasked request not blocked by in-service raises request output
// R15: request output low while write strobe low
// R16: master drives slave number, slave compares
// R17: acknowledge returns call bytes or vector
// R18: highest priority from mask and in-service
// R19: cpu gives three or two acknowledge pulses
// R20: vector mode returns one vector byte
`timescale 1ns/1ps
`include "pic_cfg.svh"
module pic_host_port (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       a0,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    input  wire logic       acknowledge_strobe_n,
    input  wire logic [7:0] peripheral_request_lines,
    output logic            int_out,
    input  wire logic       slave_n,
    input  wire logic [2:0] cascade_select_in,
    output logic      [2:0] cascade_select_out,
    output logic            cascade_select_oe
);

    // ================================================================
    // pin synchronisers
    logic [24:0] syn;
    pic_sync #(.W(25), .RST(`SYNC_RST)) u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .d       ({peripheral_request_lines, cascade_select_in,
                   slave_n, acknowledge_strobe_n, data_in, a0,
                   wr_n, rd_n, cs_n}),
        .q       (syn)
    );

    logic       s_cs_n, s_rd_n, s_wr_n, s_a0, s_ack_n, s_slave_n;
    logic [7:0] s_data, s_req;
    logic [2:0] s_cas;
    assign {s_req, s_cas, s_slave_n, s_ack_n, s_data, s_a0,
            s_wr_n, s_rd_n, s_cs_n} = syn;

    // ================================================================
    // strobe decode
    logic rd_act, wr_act, rd_prev_reg, wr_prev_reg, ack_prev_reg;
    logic rd_start, rd_end, wr_end, ack_low, ack_fall, ack_rise;
    // both strobes low decodes as nothing
    assign rd_act   = !s_cs_n && !s_rd_n && s_wr_n;  // R2 R12
    assign wr_act   = !s_cs_n && !s_wr_n && s_rd_n;  // R2 R12
    assign rd_start = rd_act && !rd_prev_reg;
    assign rd_end   = rd_prev_reg && !rd_act;
    assign wr_end   = wr_prev_reg && !wr_act;
    assign ack_low  = !s_ack_n;                      // R3
    assign ack_fall = ack_low && !ack_prev_reg;
    assign ack_rise = !ack_low && ack_prev_reg;

    pic_pkg::byte_t wdata_reg;
    logic           wa0_reg, ra0_reg;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_prev_reg  <= 1'b0;
            wr_prev_reg  <= 1'b0;
            ack_prev_reg <= 1'b0;
            wdata_reg    <= 8'h00;
            wa0_reg      <= 1'b0;
            ra0_reg      <= 1'b0;
        end else begin
            rd_prev_reg  <= rd_act;
            wr_prev_reg  <= wr_act;
            ack_prev_reg <= ack_low;
            // data is taken while the strobe is low, used at its end
            if (wr_act) begin
                wdata_reg <= s_data;
                wa0_reg   <= s_a0;
            end
            if (rd_start) begin
                ra0_reg <= s_a0;
            end
        end
    end

    logic cmd_wr, w1_hit, pe_hit, mc_hit, dat_hit;
    assign cmd_wr  = wr_end && (wa0_reg == `ADDR_CMD);
    assign w1_hit  = cmd_wr && wdata_reg[`W1_FLAG_BIT];       // R10
    assign pe_hit  = cmd_wr && !wdata_reg[`W1_FLAG_BIT]
                     && !wdata_reg[`MC_SEL_BIT];              // R10
    assign mc_hit  = cmd_wr && !wdata_reg[`W1_FLAG_BIT]
                     && wdata_reg[`MC_SEL_BIT];               // R10
    assign dat_hit = wr_end && (wa0_reg == `ADDR_DATA);

    // ================================================================
    // initialization sequence and stored words
    pic_pkg::init_state_e init_state_reg;
    pic_pkg::byte_t       w1_reg, w2_reg, w3_reg, w4_reg;
    logic single, need4, level_mode, vector_mode, slave_mode, master;
    assign single      = w1_reg[`W1_SINGLE];
    assign need4       = w1_reg[`W1_NEED_W4];
    assign level_mode  = w1_reg[`W1_LEVEL];
    assign vector_mode = w4_reg[`W4_VECTOR];
    assign slave_mode  = !single && !s_slave_n;
    assign master      = !single && s_slave_n;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            init_state_reg <= pic_pkg::INIT_NONE;
        end else if (w1_hit) begin
            init_state_reg <= pic_pkg::INIT_W2;
        end else if (dat_hit) begin
            case (init_state_reg)                             // R11
                pic_pkg::INIT_W2: begin
                    if (!single)
                        init_state_reg <= pic_pkg::INIT_W3;
                    else if (need4)
                        init_state_reg <= pic_pkg::INIT_W4;
                    else
                        init_state_reg <= pic_pkg::INIT_DONE;
                end
                pic_pkg::INIT_W3: begin
                    init_state_reg <= need4 ? pic_pkg::INIT_W4
                                            : pic_pkg::INIT_DONE;
                end
                pic_pkg::INIT_W4: init_state_reg <= pic_pkg::INIT_DONE;
                default: init_state_reg <= init_state_reg;
            endcase
        end
    end

    // write-only; no read path reaches these
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            w1_reg <= 8'h00;
            w2_reg <= 8'h00;
            w3_reg <= 8'h00;
            w4_reg <= 8'h00;
        end else if (w1_hit) begin
            w1_reg <= wdata_reg;                              // R7
            w4_reg <= 8'h00;
        end else if (dat_hit) begin
            if (init_state_reg == pic_pkg::INIT_W2)
                w2_reg <= wdata_reg;                          // R7
            if (init_state_reg == pic_pkg::INIT_W3)
                w3_reg <= wdata_reg;                          // R7
            if (init_state_reg == pic_pkg::INIT_W4)
                w4_reg <= wdata_reg;                          // R7
        end
    end

    // ================================================================
    // mode control and mask
    logic           rdsel_reg, poll_reg;
    pic_pkg::byte_t mask_reg;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdsel_reg <= 1'b0;
            poll_reg  <= 1'b0;
        end else if (w1_hit) begin
            rdsel_reg <= 1'b0;
            poll_reg  <= 1'b0;
        end else if (mc_hit) begin
            if (wdata_reg[`MC_RDEN])
                rdsel_reg <= wdata_reg[`MC_RDSEL];
            poll_reg <= wdata_reg[`MC_POLL];
        end else if (rd_end && ra0_reg == `ADDR_CMD) begin
            poll_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            mask_reg <= `MASK_RST;
        else if (w1_hit)
            mask_reg <= `MASK_RST;
        else if (dat_hit && init_state_reg == pic_pkg::INIT_DONE)
            mask_reg <= wdata_reg;                            // R11 R4
    end

    // ================================================================
    // request, priority and in-service
    pic_pkg::byte_t req_reg, isr_reg, req_prev_reg, acc_bit, clr_bit;
    logic           g_valid, b_any, accept, ack_take, poll_take;
    logic [2:0]     g_lvl, b_top, acc_lvl, ack_lvl_reg;
    logic [2:0]     poll_lvl_reg;
    logic           poll_v_reg;
    pic_pkg::ack_state_e ack_state_reg;

    pic_priority #(.N(8), .LW(3)) u_prio (
        .pend     (req_reg & ~mask_reg),                      // R4 R18
        .busy     (isr_reg),                                  // R18
        .valid    (g_valid),
        .level    (g_lvl),
        .busy_any (b_any),
        .busy_top (b_top)
    );

    assign ack_take  = ack_fall && ack_state_reg == pic_pkg::ACK_IDLE
                       && g_valid;
    assign poll_take = rd_end && ra0_reg == `ADDR_CMD && poll_reg
                       && poll_v_reg;
    assign accept    = ack_take || poll_take;
    assign acc_lvl   = ack_take ? g_lvl : poll_lvl_reg;
    assign acc_bit   = accept ? (8'h01 << acc_lvl) : 8'h00;

    always_comb begin
        clr_bit = 8'h00;
        if (pe_hit && wdata_reg[`PE_END]) begin
            if (wdata_reg[`PE_SPEC])
                clr_bit = 8'h01 << wdata_reg[2:0];
            else if (b_any)
                clr_bit = 8'h01 << b_top;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            req_prev_reg <= 8'hff;
            req_reg      <= 8'h00;
        end else begin
            req_prev_reg <= s_req;
            if (level_mode)
                req_reg <= s_req;                             // R13 R5
            else    // set wins over the acceptance clear
                req_reg <= (req_reg & ~acc_bit)
                           | (s_req & ~req_prev_reg);         // R13 R5
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            isr_reg <= 8'h00;
        else if (w1_hit)
            isr_reg <= 8'h00;
        else
            isr_reg <= (isr_reg & ~clr_bit) | acc_bit;        // R6
    end

    // ================================================================
    // acknowledge sequence
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack_state_reg <= pic_pkg::ACK_IDLE;
            ack_lvl_reg   <= 3'h0;
        end else begin
            case (ack_state_reg)                              // R19
                pic_pkg::ACK_IDLE: begin
                    if (ack_take) begin
                        ack_state_reg <= pic_pkg::ACK_P1;
                        ack_lvl_reg   <= g_lvl;
                    end
                end
                pic_pkg::ACK_P1: begin
                    if (ack_fall)
                        ack_state_reg <= pic_pkg::ACK_P2;
                end
                pic_pkg::ACK_P2: begin
                    if (ack_fall && !vector_mode)
                        ack_state_reg <= pic_pkg::ACK_P3;
                    else if (ack_rise && vector_mode)
                        ack_state_reg <= pic_pkg::ACK_IDLE;   // R20
                end
                pic_pkg::ACK_P3: begin
                    if (ack_rise)
                        ack_state_reg <= pic_pkg::ACK_IDLE;
                end
                default: ack_state_reg <= pic_pkg::ACK_IDLE;
            endcase
        end
    end

    logic           mine, ack_drive;
    pic_pkg::byte_t ack_byte, low_addr;
    // slaves answer only when the master names them
    assign mine = slave_mode ? (s_cas == w3_reg[2:0])         // R16
                             : !(master && w3_reg[ack_lvl_reg]);
    assign low_addr = w1_reg[`W1_GAP4]
        ? {w1_reg[`W1_ADDR_HI:`W1_ADDR_LO], ack_lvl_reg, 2'b00}
        : {w1_reg[`W1_ADDR_HI:6], ack_lvl_reg, 3'b000};

    always_comb begin
        ack_byte  = 8'h00;
        ack_drive = 1'b0;
        case (ack_state_reg)                                  // R17
            pic_pkg::ACK_P1: begin
                ack_byte  = `CALL_OPCODE;
                ack_drive = !vector_mode && !slave_mode;
            end
            pic_pkg::ACK_P2: begin
                ack_byte  = vector_mode ? {w2_reg[7:3], ack_lvl_reg}
                                        : low_addr;           // R20
                ack_drive = mine;
            end
            pic_pkg::ACK_P3: begin
                ack_byte  = w2_reg;
                ack_drive = mine;
            end
            default: ack_drive = 1'b0;
        endcase
        ack_drive = ack_drive && ack_low;                     // R3
    end

    // ================================================================
    // outputs
    pic_pkg::byte_t rd_byte, poll_byte;
    // latched poll result is not ready in the read's first cycle
    assign poll_byte = rd_start ? {g_valid, 4'h0, g_lvl}
                                : {poll_v_reg, 4'h0, poll_lvl_reg};
    // live address, so the first driven byte is already right
    assign rd_byte = (s_a0 == `ADDR_DATA) ? mask_reg          // R9
                   : poll_reg  ? poll_byte
                   : rdsel_reg ? isr_reg : req_reg;           // R8

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            poll_v_reg         <= 1'b0;
            poll_lvl_reg       <= 3'h0;
            data_out           <= 8'h00;
            data_oe            <= 1'b0;
            int_out            <= 1'b0;
            cascade_select_out <= 3'h0;
            cascade_select_oe  <= 1'b1;
        end else begin
            if (rd_start) begin
                poll_v_reg   <= g_valid;
                poll_lvl_reg <= g_lvl;
            end
            data_out <= rd_act ? rd_byte : ack_byte;
            data_oe  <= rd_act || ack_drive;                  // R1
            int_out  <= init_state_reg == pic_pkg::INIT_DONE
                        && g_valid && !wr_act;                // R14 R15
            cascade_select_out <= (master && ack_state_reg
                != pic_pkg::ACK_IDLE) ? ack_lvl_reg : 3'h0;   // R16
            cascade_select_oe  <= !slave_mode;
        end
    end

    // ================================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_oe_cause;
        data_oe |-> $past(rd_act) || $past(ack_low);
    endproperty
    a_oe_cause: assert property (p_oe_cause) // R1
        else $error("data port driven without select or acknowledge");

    property p_cs_guard;
        (s_cs_n && $past(s_cs_n)) |=> $stable(mask_reg);
    endproperty
    a_cs_guard: assert property (p_cs_guard) // R2
        else $error("mask changed without chip select");

    property p_ack_start;
        ack_take |=> ack_state_reg == pic_pkg::ACK_P1;
    endproperty
    a_ack_start: assert property (p_ack_start) // R3
        else $error("acknowledge not started");

    property p_mask_block;
        g_valid |-> !mask_reg[g_lvl];
    endproperty
    a_mask_block: assert property (p_mask_block) // R4
        else $error("masked level selected");

    property p_level_req;
        (level_mode && $stable(level_mode)) |=> req_reg == $past(s_req);
    endproperty
    a_level_req: assert property (p_level_req) // R13
        else $error("level request not followed");

    property p_isr_set;
        ack_take |=> isr_reg[$past(g_lvl)];
    endproperty
    a_isr_set: assert property (p_isr_set) // R6
        else $error("in-service bit not set on acknowledge");

    property p_mask_read;
        (rd_act && s_a0 == `ADDR_DATA) |=> data_out == $past(mask_reg);
    endproperty
    a_mask_read: assert property (p_mask_read) // R9
        else $error("address 1 read is not the mask");

    property p_w1_start;
        w1_hit |=> init_state_reg == pic_pkg::INIT_W2 && mask_reg == 8'h00;
    endproperty
    a_w1_start: assert property (p_w1_start) // R10
        else $error("first init word did not restart sequence");

    property p_mask_write;
        (dat_hit && init_state_reg == pic_pkg::INIT_DONE)
            |=> mask_reg == $past(wdata_reg);
    endproperty
    a_mask_write: assert property (p_mask_write) // R11
        else $error("mask not loaded after init");

    property p_int_hold;
        wr_act[*2] |-> !int_out;
    endproperty
    a_int_hold: assert property (p_int_hold) // R15
        else $error("request output high during write");

    property p_opcode;
        (ack_drive && ack_state_reg == pic_pkg::ACK_P1)
            |=> data_oe && data_out == `CALL_OPCODE;
    endproperty
    a_opcode: assert property (p_opcode) // R17
        else $error("call opcode not returned");

    c_call_seq: cover property (ack_state_reg == pic_pkg::ACK_P3
                                && ack_drive);
    c_vector: cover property (vector_mode && ack_drive
                              && ack_state_reg == pic_pkg::ACK_P2);
    c_poll: cover property (poll_take);
    c_nested: cover property (g_valid && b_any);

endmodule // pic_host_port

// >>> hw/pic_cfg.svh
/*
 holds the address codes, command and init word bit positions, mask and
 synchroniser reset values and call opcode of the host port as macros.
 assumes it is included by bare name from the design files.
*/
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

// ====================================================================
// address line meaning
`define ADDR_CMD      1'b0
`define ADDR_DATA     1'b1

// ====================================================================
// command decode at address 0
`define W1_FLAG_BIT   4
`define MC_SEL_BIT    3

// ====================================================================
// init_word_one fields
`define W1_NEED_W4    0
`define W1_SINGLE     1
`define W1_GAP4       2
`define W1_LEVEL      3
`define W1_ADDR_HI    7
`define W1_ADDR_LO    5

// ====================================================================
// init_word_four, mode_control_word, priority_end_control_word
`define W4_VECTOR     0
`define MC_RDSEL      0
`define MC_RDEN       1
`define MC_POLL       2
`define PE_END        5
`define PE_SPEC       6

// ====================================================================
// reset values and fixed codes
`define MASK_RST      8'h00
`define CALL_OPCODE   8'hcd
`define SYNC_RST      25'h1fe_3007

`endif

// >>> hw/pic_pkg.sv
/*
 types shared by the interrupt controller host port.
 assumes nothing beyond a systemverilog compiler.
*/
package pic_pkg;

    // ================================================================
    // initialization sequence
    typedef enum logic [4:0] {
        INIT_NONE = 5'b00001,
        INIT_W2   = 5'b00010,
        INIT_W3   = 5'b00100,
        INIT_W4   = 5'b01000,
        INIT_DONE = 5'b10000
    } init_state_e;

    // ================================================================
    // acknowledge pulse tracking
    typedef enum logic [3:0] {
        ACK_IDLE = 4'b0001,
        ACK_P1   = 4'b0010,
        ACK_P2   = 4'b0100,
        ACK_P3   = 4'b1000
    } ack_state_e;

    typedef logic [7:0] byte_t;

endpackage

// >>> hw/pic_sync.sv
/*
 two-flop synchroniser for a group of asynchronous pins.
 assumes each bit is independent; multi-bit words must be stable
 while sampled.
*/
`timescale 1ns/1ps
module pic_sync #(
    parameter int           W   = 25,
    parameter logic [W-1:0] RST = '1
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;

    // ================================================================
    // first stage feeds only the second
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= RST;
            q        <= RST;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule // pic_sync

// >>> hw/pic_priority.sv
/*
 fixed priority resolver: level 0 highest. also reports the highest
 priority busy level for non-specific end commands.
 assumes pend is already masked.
*/
`timescale 1ns/1ps
module pic_priority #(
    parameter int N  = 8,
    parameter int LW = 3
) (
    input  wire logic [N-1:0]  pend,
    input  wire logic [N-1:0]  busy,
    output logic               valid,
    output logic [LW-1:0]      level,
    output logic               busy_any,
    output logic [LW-1:0]      busy_top
);

    // ================================================================
    // scan downward so the lowest index decides last
    always_comb begin
        valid    = 1'b0;
        level    = '0;
        busy_any = 1'b0;
        busy_top = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                valid = 1'b1;
                level = LW'(i);
            end
            if (busy[i]) begin
                // equal or lower priority waits for service end
                valid    = 1'b0;
                busy_any = 1'b1;
                busy_top = LW'(i);
            end
        end
    end

endmodule // pic_priority

// >>> testbench/cpu_bus_model.sv
/*
 cpu side of the host port: register reads, writes, ack pulses.
 assumes a single clock; pins move only just after a rising edge.
*/
`timescale 1ns/1ps
module cpu_bus_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic            a0,
    output logic      [7:0] data_in,
    output logic            ack_n
);
    // ==========================================================
    // idle bus
    initial begin
        cs_n    = 1'b1;
        rd_n    = 1'b1;
        wr_n    = 1'b1;
        a0      = 1'b0;
        data_in = 8'h00;
        ack_n   = 1'b1;
    end

    // ==========================================================
    // accesses; strobes stay low 5 and high at least 4 cycles
    task automatic wr(input logic a, input logic [7:0] d,
                      input logic sel);
        @(posedge ref_clk);
        cs_n    <= ~sel;
        a0      <= a;
        data_in <= d;
        wr_n    <= 1'b0;
        repeat (5) @(posedge ref_clk);
        wr_n <= 1'b1;
        // data held past the synced commit edge
        repeat (3) @(posedge ref_clk);
        cs_n    <= 1'b1;
        data_in <= ~d;
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic rd(input logic a, output logic [7:0] q,
                      output logic oe);
        @(posedge ref_clk);
        cs_n <= 1'b0;
        a0   <= a;
        rd_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        q = data_out;
        oe = data_oe;
        rd_n <= 1'b1;
        cs_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask

    // one acknowledge pulse, call or vector mode
    task automatic ack(output logic [7:0] q, output logic oe);
        @(posedge ref_clk);
        ack_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        q = data_out;
        oe = data_oe;
        ack_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule // cpu_bus_model

// >>> testbench/tb_top.sv
/*
 self-checking bench for the host port in call, vector and cascade
 modes.
 assumes the partner model drives the bus pins.
*/
`timescale 1ns/1ps
module tb_top;
    logic       ref_clk = 1'b0;
    logic       resetn  = 1'b0;
    logic [7:0] req     = 8'h00;
    logic [7:0] data_out;
    logic       data_oe;
    logic       cs_n, rd_n, wr_n, a0, ack_n, int_out;
    logic [7:0] data_in;
    logic       slv_n  = 1'b1;
    logic [2:0] cas_in = 3'h0;
    logic [2:0] cas_out;
    logic       cas_oe;
    logic [7:0] ack_q;
    logic       ack_oe;
    int         fail_count = 0;
    int         cmp_count  = 0;

    always #4 ref_clk = ~ref_clk;

    cpu_bus_model u_cpu (.ref_clk(ref_clk), .data_out(data_out),
        .data_oe(data_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .a0(a0), .data_in(data_in), .ack_n(ack_n));

    // slave strap and cascade lines driven by the bench
    pic_host_port u_dut (.ref_clk(ref_clk), .resetn(resetn),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .a0(a0),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .acknowledge_strobe_n(ack_n), .peripheral_request_lines(req),
        .int_out(int_out), .slave_n(slv_n),
        .cascade_select_in(cas_in), .cascade_select_out(cas_out),
        .cascade_select_oe(cas_oe));

    // ==========================================================
    // checks and closing
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rdc(input string n, input logic a,
                       input logic [7:0] e);
        logic [7:0] q;
        logic       oe;
        u_cpu.rd(a, q, oe);
        chk(n, e, q);
        chk(n, 8'h01, {7'h00, oe});
    endtask

    task automatic ackc(input string n, input logic [7:0] e);
        logic [7:0] q;
        logic       oe;
        u_cpu.ack(q, oe);
        chk(n, e, q);
        chk(n, 8'h01, {7'h00, oe});
    endtask

    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // run is near 370 cycles; over sixteen times that is a hang
    initial begin
        repeat (6000) @(posedge ref_clk);
        fail_count++;
        end_sim();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        chk("int_rst", 8'h00, {7'h00, int_out});
        chk("oe_rst", 8'h00, {7'h00, data_oe});
        u_cpu.wr(1'b0, 8'hb7, 1'b1);
        u_cpu.wr(1'b1, 8'h12, 1'b1);
        u_cpu.wr(1'b1, 8'h00, 1'b1);
        u_cpu.wr(1'b1, 8'hf0, 1'b1);
        rdc("mask", 1'b1, 8'hf0);
        chk("oe_idle", 8'h00, {7'h00, data_oe});
        u_cpu.wr(1'b1, 8'h55, 1'b0);
        rdc("mask_cs", 1'b1, 8'hf0);
        req <= 8'h20;
        repeat (6) @(posedge ref_clk);
        chk("int_masked", 8'h00, {7'h00, int_out});
        req <= 8'h24;
        repeat (6) @(posedge ref_clk);
        chk("int_req", 8'h01, {7'h00, int_out});
        rdc("request", 1'b0, 8'h24);
        fork
            u_cpu.wr(1'b0, 8'h0b, 1'b1);
            begin
                repeat (5) @(posedge ref_clk);
                chk("int_wr", 8'h00, {7'h00, int_out});
            end
        join
        ackc("opcode", 8'hcd);
        ackc("addr_lo", 8'ha8);
        ackc("addr_hi", 8'h12);
        rdc("in_service", 1'b0, 8'h04);
        u_cpu.wr(1'b0, 8'h20, 1'b1);
        rdc("in_svc_end", 1'b0, 8'h00);
        req <= 8'h00;
        repeat (4) @(posedge ref_clk);
        req <= 8'h02;
        u_cpu.wr(1'b0, 8'h0c, 1'b1);
        rdc("poll", 1'b0, 8'h81);
        // cascade master, level trigger, vector replies
        u_cpu.wr(1'b0, 8'h19, 1'b1);
        u_cpu.wr(1'b1, 8'h48, 1'b1);
        u_cpu.wr(1'b1, 8'h00, 1'b1);
        u_cpu.wr(1'b1, 8'h01, 1'b1);
        rdc("lvl_req", 1'b0, 8'h02);
        chk("cas_oe_m", 8'h01, {7'h00, cas_oe});
        u_cpu.ack(ack_q, ack_oe);
        chk("vec_p1", 8'h00, {7'h00, ack_oe});
        chk("cas_lvl", 8'h01, {5'h00, cas_out});
        ackc("vector", 8'h49);
        // cascade slave: answers only to its own number
        slv_n  <= 1'b0;
        cas_in <= 3'h3;
        u_cpu.wr(1'b0, 8'h19, 1'b1);
        u_cpu.wr(1'b1, 8'h48, 1'b1);
        u_cpu.wr(1'b1, 8'h05, 1'b1);
        u_cpu.wr(1'b1, 8'h01, 1'b1);
        chk("cas_oe_s", 8'h00, {7'h00, cas_oe});
        u_cpu.ack(ack_q, ack_oe);
        u_cpu.ack(ack_q, ack_oe);
        chk("slv_other", 8'h00, {7'h00, ack_oe});
        u_cpu.wr(1'b0, 8'h20, 1'b1);
        cas_in <= 3'h5;
        u_cpu.ack(ack_q, ack_oe);
        ackc("slv_vec", 8'h49);
        end_sim();
    end
endmodule // tb_top
